// *** cgs_cfg.svh ***
// Purpose: constants of the clock synthesizer control bytes
// Assumes: master clock of 20 MHz
// Notes:   offsets are the byte offsets carried in the command code
`ifndef CGS_CFG_SVH
`define CGS_CFG_SVH

`define CGS_MCLK_KHZ       20000
`define CGS_UNIT_SHORT_MS  150
`define CGS_UNIT_LONG_MS   2500
`define CGS_RST_PULSE_US   100
`define CGS_SLAVE_ADDR     7'h69

`define CGS_OFF_B3         7'h03
`define CGS_OFF_B4         7'h04
`define CGS_OFF_B5         7'h05
`define CGS_OFF_B6         7'h06
`define CGS_OFF_B7         7'h07
`define CGS_OFF_B8         7'h08
`define CGS_OFF_B9         7'h09

`define CGS_RST_B3         8'h3f
`define CGS_RST_B4         8'h3e
`define CGS_RST_B5         8'hf3
`define CGS_RSVD_VAL       8'hff
`define CGS_WMASK_B3       8'h7f
`define CGS_WMASK_B5       8'hf3

`define CGS_B3_FSEL        6
`define CGS_B3_USB         5
`define CGS_B3_SIO         4
`define CGS_B3_PCIF        3
`define CGS_B3_GPC         2
`define CGS_B3_GPB         1
`define CGS_B3_GPA         0
`define CGS_B4_SKEW_HI     7
`define CGS_B4_SKEW_LO     6
`define CGS_B4_CNT_HI      5
`define CGS_B4_CNT_LO      1
`define CGS_B4_UNIT        0
`define CGS_B5_USB_DRV     7
`define CGS_B5_SIO_DRV     6
`define CGS_B5_INTC_B      5
`define CGS_B5_INTC_A      4
`define CGS_B5_REF_B       1
`define CGS_B5_REF_A       0
`define CGS_B9_RST_EN      4
`define CGS_B9_STATUS      2
`define CGS_B9_RUN         1

`define CGS_SKEW_RSVD      2'b10
`define CGS_SKEW_NOM       2'b00
`define CGS_CMD_BYTE_BIT   7

`endif

// *** cgs_ctrl.sv ***
// Purpose: serial control bytes 3 to 9 of a clock synthesizer
// Assumes: i_lclk oversamples the serial pins, i_mclk is 20 MHz
// Notes:   bus link on i_lclk, control bytes and guard timer on i_mclk
`include "cgs_cfg.svh"

module cgs_ctrl import cgs_pkg::*; #(
  parameter logic [6:0]  SLAVE_ADDR = `CGS_SLAVE_ADDR,
  parameter logic [3:0]  REV_CODE   = 4'h5,  // arbitrary value
  parameter logic [3:0]  MAKER_CODE = 4'h3,  // arbitrary value
  parameter int unsigned SHORT_CYC  = `CGS_UNIT_SHORT_MS * `CGS_MCLK_KHZ,
  parameter int unsigned LONG_CYC   = `CGS_UNIT_LONG_MS * `CGS_MCLK_KHZ
) (
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  input  wire logic       i_lclk,
  input  wire logic       i_smb_scl,
  input  wire logic       i_smb_sda,
  output logic            o_smb_scl_o,
  output logic            o_smb_scl_oe_n,
  output logic            o_smb_sda_o,
  output logic            o_smb_sda_oe_n,
  output logic            o_sys_rst_n_o,
  output logic            o_sys_rst_n_oe_n,
  output logic            o_periph_clk_freq_select,
  output logic            o_usb_clk_run,
  output logic            o_superio_clk_run,
  output logic            o_pci_free_clk_run,
  output logic            o_graphics_port_clk_a_run,
  output logic            o_graphics_port_clk_b_run,
  output logic            o_graphics_port_clk_c_run,
  output logic            o_intc_clk_a_run,
  output logic            o_intc_clk_b_run,
  output logic            o_ref_clk_a_run,
  output logic            o_ref_clk_b_run,
  output logic [1:0]      o_pci_clk_shift,
  output logic            o_usb_clk_strength,
  output logic            o_superio_clk_strength,
  output logic            o_guard_expired_flag
);

  cgs_link_s lq;
  cgs_link_s next_lq;
  cgs_main_s mq;
  cgs_main_s next_mq;

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       ack_evt;
  logic       req_evt;
  logic       g_expire;
  logic       g_rst_oe_n;
  logic [7:0] rd_byte;

  // ---------------- link domain (i_lclk) ----------------

  assign scl_rise  = lq.scl_s2 & ~lq.scl_s3;
  assign scl_fall  = ~lq.scl_s2 & lq.scl_s3;
  assign bus_start = lq.scl_s2 & lq.scl_s3 & lq.sda_s3 & ~lq.sda_s2;
  assign bus_stop  = lq.scl_s2 & lq.scl_s3 & ~lq.sda_s3 & lq.sda_s2;
  assign ack_evt   = lq.ack_s2 ^ lq.ack_s3;

  always_comb begin
    next_lq        = lq;
    next_lq.scl_s1 = i_smb_scl;
    next_lq.scl_s2 = lq.scl_s1;
    next_lq.scl_s3 = lq.scl_s2;
    next_lq.sda_s1 = i_smb_sda;
    next_lq.sda_s2 = lq.sda_s1;
    next_lq.sda_s3 = lq.sda_s2;
    next_lq.ack_s1 = mq.ack_tgl;
    next_lq.ack_s2 = lq.ack_s1;
    next_lq.ack_s3 = lq.ack_s2;
    if (lq.st == LS_WAIT) begin
      // clock held low by us, so no start, stop or edge can come now
      if (ack_evt) begin
        next_lq.scl_rel = 1'b1;
        next_lq.ackph   = 1'b1;
        next_lq.sh      = mq.rdat;
        next_lq.st      = lq.rd ? LS_RDATA : LS_SKIP;
      end
    end else if (bus_start) begin
      next_lq.st      = LS_ADDR;
      next_lq.bcnt    = 4'h0;
      next_lq.ackph   = 1'b0;
      next_lq.sda_rel = 1'b1;
    end else if (bus_stop) begin
      next_lq.st      = LS_IDLE;
      next_lq.ackph   = 1'b0;
      next_lq.sda_rel = 1'b1;
    end else if (scl_rise) begin
      if (lq.st == LS_MACK) begin
        next_lq.st = LS_SKIP;
      end else if (!lq.ackph && lq.bcnt != 4'h8) begin
        next_lq.bcnt = lq.bcnt + 4'h1;
        if (lq.st == LS_RDATA) begin
          next_lq.sh = {lq.sh[6:0], 1'b0};
        end else begin
          next_lq.sh = {lq.sh[6:0], lq.sda_s2};
        end
      end
    end else if (scl_fall) begin
      if (lq.ackph) begin
        next_lq.ackph   = 1'b0;
        next_lq.bcnt    = 4'h0;
        next_lq.sda_rel = (lq.st == LS_RDATA) ? lq.sh[7] : 1'b1;
      end else if (lq.st == LS_RDATA) begin
        if (lq.bcnt == 4'h8) begin
          next_lq.sda_rel = 1'b1;
          next_lq.st      = LS_MACK;
        end else begin
          next_lq.sda_rel = lq.sh[7];
        end
      end else if (lq.bcnt == 4'h8) begin
        if (lq.st == LS_ADDR) begin
          if (lq.sh[7:1] != SLAVE_ADDR) begin
            next_lq.st = LS_SKIP;
          end else if (!lq.sh[0]) begin
            next_lq.ackph   = 1'b1;
            next_lq.sda_rel = 1'b0;
            next_lq.rd      = 1'b0;
            next_lq.st      = LS_CMD;
          end else if (lq.have_off) begin
            // stretch the clock until the byte comes back from i_mclk
            next_lq.sda_rel = 1'b0;
            next_lq.rd      = 1'b1;
            next_lq.req_wr  = 1'b0;
            next_lq.req_tgl = ~lq.req_tgl;
            next_lq.scl_rel = 1'b0;
            next_lq.st      = LS_WAIT;
          end else begin
            next_lq.st = LS_SKIP;
          end
        end else if (lq.st == LS_CMD) begin
          if (lq.sh[`CGS_CMD_BYTE_BIT]) begin
            next_lq.ackph    = 1'b1;
            next_lq.sda_rel  = 1'b0;
            next_lq.off      = lq.sh[6:0];
            next_lq.have_off = 1'b1;
            next_lq.st       = LS_WDATA;
          end else begin
            next_lq.st = LS_SKIP;
          end
        end else if (lq.st == LS_WDATA) begin
          // only one data byte per command; later bytes are refused
          next_lq.sda_rel = 1'b0;
          next_lq.req_dat = lq.sh;
          next_lq.req_wr  = 1'b1;
          next_lq.req_tgl = ~lq.req_tgl;
          next_lq.scl_rel = 1'b0;
          next_lq.st      = LS_WAIT;
        end
      end
    end
  end

  always_ff @(posedge i_lclk or negedge i_nrst) begin
    if (!i_nrst) begin
      lq <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1,
              sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1,
              ack_s1: 1'b0, ack_s2: 1'b0, ack_s3: 1'b0,
              st: LS_IDLE, bcnt: 4'h0, sh: 8'h00, ackph: 1'b0, rd: 1'b0,
              have_off: 1'b0, off: 7'h00, sda_rel: 1'b1, scl_rel: 1'b1,
              req_tgl: 1'b0, req_wr: 1'b0, req_dat: 8'h00};
    end else begin
      lq <= next_lq;
    end
  end

  // ---------------- control domain (i_mclk) ----------------

  assign req_evt = mq.req_s2 ^ mq.req_s3;

  always_comb begin
    unique case (lq.off)
      `CGS_OFF_B3: rd_byte = mq.b3;
      `CGS_OFF_B4: rd_byte = mq.b4;
      `CGS_OFF_B5: rd_byte = mq.b5;
      `CGS_OFF_B6: rd_byte = `CGS_RSVD_VAL;
      `CGS_OFF_B7: rd_byte = `CGS_RSVD_VAL;
      `CGS_OFF_B8: rd_byte = {REV_CODE, MAKER_CODE};
      `CGS_OFF_B9: rd_byte = {3'h0, mq.rst_en, 1'b0, mq.status, mq.run, 1'b0};
      default:     rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    next_mq        = mq;
    next_mq.req_s1 = lq.req_tgl;
    next_mq.req_s2 = mq.req_s1;
    next_mq.req_s3 = mq.req_s2;
    // request fields are held steady by the link while it waits for the ack
    if (req_evt) begin
      if (lq.req_wr) begin
        unique case (lq.off)
          `CGS_OFF_B3: next_mq.b3 = lq.req_dat & `CGS_WMASK_B3;
          `CGS_OFF_B4: next_mq.b4 = lq.req_dat;
          `CGS_OFF_B5: next_mq.b5 = lq.req_dat & `CGS_WMASK_B5;
          `CGS_OFF_B9: begin
            next_mq.rst_en = lq.req_dat[`CGS_B9_RST_EN];
            next_mq.run    = lq.req_dat[`CGS_B9_RUN];
            if (lq.req_dat[`CGS_B9_STATUS]) begin
              next_mq.status = 1'b0;
            end
          end
          default: next_mq.rdat = mq.rdat;
        endcase
      end else begin
        next_mq.rdat = rd_byte;
      end
      next_mq.ack_tgl = ~mq.ack_tgl;
    end
    // expiry after the clear so a same-cycle event is kept
    if (g_expire) begin
      next_mq.status = 1'b1;
    end
    if (next_mq.b4[`CGS_B4_SKEW_HI:`CGS_B4_SKEW_LO] == `CGS_SKEW_RSVD) begin
      next_mq.pci_shift = `CGS_SKEW_NOM;
    end else begin
      next_mq.pci_shift = next_mq.b4[`CGS_B4_SKEW_HI:`CGS_B4_SKEW_LO];
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      mq <= '{req_s1: 1'b0, req_s2: 1'b0, req_s3: 1'b0, ack_tgl: 1'b0,
              rdat: 8'h00, b3: `CGS_RST_B3, b4: `CGS_RST_B4, b5: `CGS_RST_B5,
              rst_en: 1'b0, status: 1'b0, run: 1'b0, pci_shift: `CGS_SKEW_NOM};
    end else begin
      mq <= next_mq;
    end
  end

  cgs_guard #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC)
  ) u_guard (
    .i_mclk     (i_mclk),
    .i_nrst     (i_nrst),
    .i_run      (mq.run),
    .i_count    (mq.b4[`CGS_B4_CNT_HI:`CGS_B4_CNT_LO]),
    .i_unit_sel (mq.b4[`CGS_B4_UNIT]),
    .i_rst_en   (mq.rst_en),
    .o_expire   (g_expire),
    .o_rst_oe_n (g_rst_oe_n)
  );

  // open-drain pins only ever pull low
  assign o_smb_scl_o    = 1'b0;
  assign o_smb_scl_oe_n = lq.scl_rel;
  assign o_smb_sda_o    = 1'b0;
  assign o_smb_sda_oe_n = lq.sda_rel;
  assign o_sys_rst_n_o    = 1'b0;
  assign o_sys_rst_n_oe_n = g_rst_oe_n;

  assign o_periph_clk_freq_select  = mq.b3[`CGS_B3_FSEL];
  assign o_usb_clk_run             = mq.b3[`CGS_B3_USB];
  assign o_superio_clk_run         = mq.b3[`CGS_B3_SIO];
  assign o_pci_free_clk_run        = mq.b3[`CGS_B3_PCIF];
  assign o_graphics_port_clk_a_run = mq.b3[`CGS_B3_GPA];
  assign o_graphics_port_clk_b_run = mq.b3[`CGS_B3_GPB];
  assign o_graphics_port_clk_c_run = mq.b3[`CGS_B3_GPC];
  assign o_intc_clk_a_run          = mq.b5[`CGS_B5_INTC_A];
  assign o_intc_clk_b_run          = mq.b5[`CGS_B5_INTC_B];
  assign o_ref_clk_a_run           = mq.b5[`CGS_B5_REF_A];
  assign o_ref_clk_b_run           = mq.b5[`CGS_B5_REF_B];
  assign o_pci_clk_shift           = mq.pci_shift;
  assign o_usb_clk_strength        = mq.b5[`CGS_B5_USB_DRV];
  assign o_superio_clk_strength    = mq.b5[`CGS_B5_SIO_DRV];
  assign o_guard_expired_flag      = mq.status;

endmodule : cgs_ctrl

// *** cgs_ctrl_asserts.sv ***
// Purpose: port assertions of the control byte block
// Assumes: reset pulse of 2000 control clocks
// Notes:   bound into every cgs_ctrl instance
module cgs_ctrl_asserts import cgs_pkg::*; (
  input wire logic       i_mclk,
  input wire logic       i_nrst,
  input wire logic       i_lclk,
  input wire logic       i_smb_scl,
  input wire logic       o_smb_scl_o,
  input wire logic       o_smb_sda_o,
  input wire logic       o_smb_sda_oe_n,
  input wire logic       o_sys_rst_n_o,
  input wire logic       o_sys_rst_n_oe_n,
  input wire logic       o_periph_clk_freq_select,
  input wire logic       o_usb_clk_run,
  input wire logic       o_superio_clk_run,
  input wire logic       o_pci_free_clk_run,
  input wire logic       o_graphics_port_clk_a_run,
  input wire logic       o_graphics_port_clk_b_run,
  input wire logic       o_graphics_port_clk_c_run,
  input wire logic       o_intc_clk_a_run,
  input wire logic       o_intc_clk_b_run,
  input wire logic       o_ref_clk_a_run,
  input wire logic       o_ref_clk_b_run,
  input wire logic [1:0] o_pci_clk_shift,
  input wire logic       o_usb_clk_strength,
  input wire logic       o_superio_clk_strength,
  input wire logic       o_guard_expired_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] low_cnt;
  wire logic   all_run = &{o_usb_clk_run, o_superio_clk_run, o_pci_free_clk_run,
    o_graphics_port_clk_a_run, o_graphics_port_clk_b_run, o_graphics_port_clk_c_run,
    o_intc_clk_a_run, o_intc_clk_b_run, o_ref_clk_a_run, o_ref_clk_b_run};
  // counts the reset pulse, too long for a repetition
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      low_cnt <= 12'h000;
    end else begin
      low_cnt <= o_sys_rst_n_oe_n ? 12'h000 : low_cnt + 12'h001;
    end
  end
  property p_shift_legal;
    @(posedge i_mclk) disable iff (!i_nrst) o_pci_clk_shift != 2'b10;
  endproperty
  a_shift_legal: assert property (p_shift_legal)
    else $error("pci shift shows reserved code");
  property p_rst_run;
    @(posedge i_mclk) disable iff (!i_nrst) !$past(i_nrst) |-> all_run;
  endproperty
  a_rst_run: assert property (p_rst_run)
    else $error("clock outputs not running after reset");
  property p_rst_drv;
    @(posedge i_mclk) disable iff (!i_nrst)
      !$past(i_nrst) |-> o_usb_clk_strength && o_superio_clk_strength;
  endproperty
  a_rst_drv: assert property (p_rst_drv)
    else $error("drive strength not high after reset");
  property p_rst_freq;
    @(posedge i_mclk) disable iff (!i_nrst) !$past(i_nrst) |->
      !o_periph_clk_freq_select && o_pci_clk_shift == 2'b00 && !o_guard_expired_flag;
  endproperty
  a_rst_freq: assert property (p_rst_freq)
    else $error("select, shift or flag wrong after reset");
  property p_pulse_flag;
    // flag is registered one control clock after the pulse starts
    @(posedge i_mclk) disable iff (!i_nrst) $fell(o_sys_rst_n_oe_n) |=> o_guard_expired_flag;
  endproperty
  a_pulse_flag: assert property (p_pulse_flag)
    else $error("reset pulse without expired flag");
  property p_pulse_hold;
    @(posedge i_mclk) disable iff (!i_nrst) $fell(o_sys_rst_n_oe_n) |=> !o_sys_rst_n_oe_n [*8];
  endproperty
  a_pulse_hold: assert property (p_pulse_hold)
    else $error("reset pulse too short");
  property p_pulse_len;
    @(posedge i_mclk) disable iff (!i_nrst) $rose(o_sys_rst_n_oe_n) |-> low_cnt == 12'h7d0;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("reset pulse length wrong");
  property p_od_low;
    @(posedge i_mclk) disable iff (!i_nrst) !o_smb_scl_o && !o_smb_sda_o && !o_sys_rst_n_o;
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open drain value not low");
  property p_sda_scl_low;
    @(posedge i_lclk) disable iff (!i_nrst) $changed(o_smb_sda_oe_n) |-> !i_smb_scl;
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low)
    else $error("device moved data while clock high");
endmodule : cgs_ctrl_asserts

bind cgs_ctrl cgs_ctrl_asserts cgs_ctrl_asserts_i (.*);

// *** cgs_guard.sv ***
// Purpose: guard timer that counts down and asks for a system reset
// Assumes: i_run, i_count and i_unit_sel come from the i_mclk domain
// Notes:   stays expired until i_run is cleared, then reloads
`include "cgs_cfg.svh"

module cgs_guard import cgs_pkg::*; #(
  parameter int unsigned SHORT_CYC = `CGS_UNIT_SHORT_MS * `CGS_MCLK_KHZ,
  parameter int unsigned LONG_CYC  = `CGS_UNIT_LONG_MS * `CGS_MCLK_KHZ,
  parameter int unsigned PULSE_CYC = `CGS_RST_PULSE_US * `CGS_MCLK_KHZ / 1000
) (
  input  wire logic       i_mclk,
  input  wire logic       i_nrst,
  input  wire logic       i_run,
  input  wire logic [4:0] i_count,
  input  wire logic       i_unit_sel,
  input  wire logic       i_rst_en,
  output logic            o_expire,
  output logic            o_rst_oe_n
);

  cgs_guard_s q;
  cgs_guard_s next_q;
  logic [25:0] unit_last;

  assign unit_last = i_unit_sel ? 26'(LONG_CYC - 1) : 26'(SHORT_CYC - 1);

  always_comb begin
    next_q        = q;
    next_q.expire = 1'b0;
    if (q.rst_cnt != 12'h000) begin
      next_q.rst_cnt = q.rst_cnt - 12'h001;
    end
    if (!i_run) begin
      // count field n gives n+1 units, so 0..31 spans one to 32 units
      next_q.pre  = 26'h0000000;
      next_q.left = {1'b0, i_count} + 6'h01;
      next_q.done = 1'b0;
    end else if (!q.done) begin
      if (q.pre == unit_last) begin
        next_q.pre  = 26'h0000000;
        next_q.left = q.left - 6'h01;
        if (q.left == 6'h01) begin
          next_q.expire = 1'b1;
          next_q.done   = 1'b1;
          if (i_rst_en) begin
            next_q.rst_cnt = 12'(PULSE_CYC);
          end
        end
      end else begin
        next_q.pre = q.pre + 26'h0000001;
      end
    end
    next_q.rst_oe_n = (next_q.rst_cnt == 12'h000);
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '{pre: 26'h0000000, left: 6'h00, done: 1'b0, expire: 1'b0,
             rst_cnt: 12'h000, rst_oe_n: 1'b1};
    end else begin
      q <= next_q;
    end
  end

  assign o_expire   = q.expire;
  assign o_rst_oe_n = q.rst_oe_n;

endmodule : cgs_guard

// *** cgs_host_bfm.sv ***
// Purpose: serial bus host for the control byte block
// Assumes: pull-ups on both wires, phases of 5 bench clocks
// Notes:   waits for clock stretching, bounded
`include "cgs_cfg.svh"

module cgs_host_bfm import cgs_pkg::*; (
  input  wire logic i_clk,
  input  wire logic i_dev_scl_oe_n,
  input  wire logic i_dev_sda_oe_n,
  output logic      o_scl,
  output logic      o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;
  int   tmo_cnt = 0;
  // released wires float high through the pull-ups
  assign o_scl = scl_drv & i_dev_scl_oe_n;
  assign o_sda = sda_drv & i_dev_sda_oe_n;
  task automatic half();
    repeat (5) @(posedge i_clk);
    #1;
  endtask : half
  // sda moves one clock after scl falls, never in the step where scl moves,
  // or the device could see a false start or stop
  task automatic set_sda(input logic b);
    @(posedge i_clk);
    #1;
    sda_drv = b;
    repeat (4) @(posedge i_clk);
    #1;
  endtask : set_sda
  task automatic clk_bit(input logic b, output logic r);
    set_sda(b);
    scl_drv = 1'b1;
    for (int i = 0; i < 200 && o_scl !== 1'b1; i++) begin
      @(posedge i_clk);
    end
    if (o_scl !== 1'b1) begin
      tmo_cnt++;
    end
    half();
    r = o_sda;
    scl_drv = 1'b0;
  endtask : clk_bit
  task automatic start();
    set_sda(1'b1);
    scl_drv = 1'b1;
    half();
    sda_drv = 1'b0;
    half();
    scl_drv = 1'b0;
  endtask : start
  task automatic stop();
    set_sda(1'b0);
    scl_drv = 1'b1;
    half();
    sda_drv = 1'b1;
    half();
  endtask : stop
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], r);
    end
    clk_bit(1'b1, r);
    ack = !r;
  endtask : tx
  task automatic write_byte(input logic [7:0] cmd, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    tx({`CGS_SLAVE_ADDR, 1'b0}, a0);
    tx(cmd, a1);
    tx(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : write_byte
  task automatic read_byte(input logic [7:0] cmd, output logic [7:0] d, output logic ok);
    logic a0, a1, a2, r;
    start();
    tx({`CGS_SLAVE_ADDR, 1'b0}, a0);
    tx(cmd, a1);
    start();
    tx({`CGS_SLAVE_ADDR, 1'b1}, a2);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(1'b1, r);
    stop();
    ok = a0 & a1 & a2;
  endtask : read_byte
endmodule : cgs_host_bfm

// *** cgs_pkg.sv ***
// Purpose: types of the clock synthesizer control bytes
// Assumes: nothing
// Notes:   one state struct per clock domain of the control block, one for the guard timer
package cgs_pkg;

  typedef enum logic [2:0] {
    LS_IDLE  = 3'b000,
    LS_ADDR  = 3'b001,
    LS_CMD   = 3'b010,
    LS_WDATA = 3'b011,
    LS_WAIT  = 3'b100,
    LS_RDATA = 3'b101,
    LS_MACK  = 3'b110,
    LS_SKIP  = 3'b111
  } cgs_link_e;

  typedef struct packed {
    logic       scl_s1, scl_s2, scl_s3;
    logic       sda_s1, sda_s2, sda_s3;
    logic       ack_s1, ack_s2, ack_s3;
    cgs_link_e  st;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic       ackph;
    logic       rd;
    logic       have_off;
    logic [6:0] off;
    logic       sda_rel;
    logic       scl_rel;
    logic       req_tgl;
    logic       req_wr;
    logic [7:0] req_dat;
  } cgs_link_s;

  typedef struct packed {
    logic       req_s1, req_s2, req_s3;
    logic       ack_tgl;
    logic [7:0] rdat;
    logic [7:0] b3;
    logic [7:0] b4;
    logic [7:0] b5;
    logic       rst_en;
    logic       status;
    logic       run;
    logic [1:0] pci_shift;
  } cgs_main_s;

  typedef struct packed {
    logic [25:0] pre;
    logic [5:0]  left;
    logic        done;
    logic        expire;
    logic [11:0] rst_cnt;
    logic        rst_oe_n;
  } cgs_guard_s;

endpackage : cgs_pkg

// *** tb.sv ***
// Purpose: self-checking bench of the control byte block
// Assumes: short guard units of 20 and 40 clocks
// Notes:   flag timing window allows for frame tail after the write
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end

module tb import cgs_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic       mclk, lclk, nrst, scl, sda, scl_oe_n, sda_oe_n, rst_oe_n, fsel, flag;
  logic       usb, sio, pcif, gpa, gpb, gpc, ica, icb, rfa, rfb, usbs, sios;
  logic [1:0] shift;
  int         error_cnt, check_count;
  logic [7:0] v3 [4] = '{8'h40, 8'h2a, 8'h15, 8'h3f};
  logic [7:0] v5 [4] = '{8'h00, 8'hc2, 8'h31, 8'hf3};
  wire logic [7:0] b3_out = {1'b0, fsel, usb, sio, pcif, gpc, gpb, gpa};
  wire logic [7:0] b5_out = {usbs, sios, icb, ica, 2'b00, rfb, rfa};
  always #25 mclk = ~mclk;
  always #24 lclk = ~lclk;
  cgs_host_bfm host_i (.i_clk(mclk), .i_dev_scl_oe_n(scl_oe_n), .i_dev_sda_oe_n(sda_oe_n),
    .o_scl(scl), .o_sda(sda));
  cgs_ctrl #(.SHORT_CYC(20), .LONG_CYC(40)) cgs_ctrl_i (.i_mclk(mclk), .i_nrst(nrst),
    .i_lclk(lclk), .i_smb_scl(scl), .i_smb_sda(sda), .o_smb_scl_o(),
    .o_smb_scl_oe_n(scl_oe_n), .o_smb_sda_o(), .o_smb_sda_oe_n(sda_oe_n),
    .o_sys_rst_n_o(), .o_sys_rst_n_oe_n(rst_oe_n), .o_periph_clk_freq_select(fsel),
    .o_usb_clk_run(usb), .o_superio_clk_run(sio), .o_pci_free_clk_run(pcif),
    .o_graphics_port_clk_a_run(gpa), .o_graphics_port_clk_b_run(gpb),
    .o_graphics_port_clk_c_run(gpc), .o_intc_clk_a_run(ica), .o_intc_clk_b_run(icb),
    .o_ref_clk_a_run(rfa), .o_ref_clk_b_run(rfb), .o_pci_clk_shift(shift),
    .o_usb_clk_strength(usbs), .o_superio_clk_strength(sios), .o_guard_expired_flag(flag));
  task automatic give_verdict();
    error_cnt += host_i.tmo_cnt;
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [6:0] off, input logic [7:0] d);
    logic ok;
    host_i.write_byte({1'b1, off}, d, ok);
    `CHK(ok, 1'b1)
  endtask : wr
  task automatic rd(input logic [6:0] off, input logic [7:0] e);
    logic ok;
    logic [7:0] d;
    host_i.read_byte({1'b1, off}, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask : rd
  task automatic guard_run(input logic [7:0] b4, input logic [7:0] b9, input int exp);
    int n;
    n = 0;
    wr(7'h09, 8'h04);
    `CHK(flag, 1'b0)
    wr(7'h04, b4);
    wr(7'h09, b9);
    while (flag !== 1'b1 && n < exp + 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    `CHK(n >= exp - 26 && n <= exp - 12, 1'b1)
  endtask : guard_run
  initial begin
    logic ok;
    mclk = 1'b0;
    lclk = 1'b0;
    nrst = 1'b0;
    error_cnt = 0;
    check_count = 0;
    repeat (4) @(posedge mclk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    `CHK(b3_out, 8'h3f)
    `CHK(b5_out, 8'hf3)
    rd(7'h03, 8'h3f);
    rd(7'h04, 8'h3e);
    rd(7'h05, 8'hf3);
    rd(7'h06, 8'hff);
    rd(7'h07, 8'hff);
    rd(7'h02, 8'h00);
    wr(7'h08, 8'h00);
    rd(7'h08, 8'h53);
    for (int i = 0; i < 4; i++) begin
      wr(7'h03, v3[i]);
      `CHK(b3_out, v3[i])
      rd(7'h03, v3[i]);
      wr(7'h05, v5[i]);
      `CHK(b5_out, v5[i])
      wr(7'h04, {i[1:0], 6'h00});
      `CHK(shift, (i == 2) ? 2'b00 : i[1:0])
    end
    host_i.write_byte({1'b0, 7'h03}, 8'h00, ok);
    `CHK(ok, 1'b0)
    `CHK(b3_out, 8'h3f)
    guard_run(8'h03, 8'h02, 80);
    `CHK(rst_oe_n, 1'b1)
    rd(7'h09, 8'h06);
    wr(7'h09, 8'h02);
    rd(7'h09, 8'h06);
    guard_run(8'h3e, 8'h02, 640);
    guard_run(8'h04, 8'h12, 60);
    `CHK(rst_oe_n, 1'b0)
    for (int i = 0; i < 2100 && rst_oe_n !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    `CHK(rst_oe_n, 1'b1)
    give_verdict();
  end
endmodule : tb
